// ### common/atdsc_consts.svh
// constants for the converter trigger and sequence control block
// assumes inclusion by bare name from the package and the design files
`ifndef ATDSC_CONSTS_SVH
`define ATDSC_CONSTS_SVH
// ****************************************
// channels, widths, reset values
// ****************************************
`define ATDSC_NCH 10
`define ATDSC_CHW 4
`define ATDSC_RESW 12
`define ATDSC_TRIG_SRC_RST 4'h9
`define ATDSC_LAST_CH 4'h9
`define ATDSC_DIEN_RST 10'h000
// resolution select codes
`define ATDSC_RES_8 2'h0
`define ATDSC_RES_10 2'h1
`define ATDSC_RES_12 2'h2
// bit counts per resolution
`define ATDSC_BITS_8 4'h8
`define ATDSC_BITS_10 4'hA
`define ATDSC_BITS_12 4'hC
`endif

// ### common/atdsc_pkg.sv
// types for the converter trigger and sequence control block
// assumes the constants header is on the include path
`include "atdsc_consts.svh"
package atdsc_pkg;
  typedef enum logic [1:0] {
    ATDSC_OFF = 2'b00,
    ATDSC_SAMPLE = 2'b01,
    ATDSC_CONVERT = 2'b10,
    ATDSC_DONE = 2'b11
  } atdsc_state_t;
endpackage : atdsc_pkg

// ### logic/atdsc_sar.sv
// successive approximation engine for one conversion
// assumes comp_i answers the current trial code within the same cycle
`timescale 1ns/1ps
`include "atdsc_consts.svh"
module atdsc_sar
  import atdsc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [1:0] res_i,
  input wire logic comp_i,
  output logic [`ATDSC_RESW-1:0] trial_o,
  output logic busy_o,
  output logic done_o,
  output logic [`ATDSC_RESW-1:0] result_o
);
  typedef struct packed {
    logic [`ATDSC_RESW-1:0] code;
    logic [`ATDSC_RESW-1:0] bitmask;
    logic [`ATDSC_RESW-1:0] trial;
    logic busy;
    logic done;
  } atdsc_sar_st_t;
  atdsc_sar_st_t s_r, s_nxt;
  logic [3:0] nbits;

  // ****************************************
  // binary search, msb first
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    nbits = (res_i == `ATDSC_RES_8) ? `ATDSC_BITS_8 : (res_i == `ATDSC_RES_10) ? `ATDSC_BITS_10 : `ATDSC_BITS_12;
    if (start_i && !s_r.busy) begin
      // test bit starts at the resolution msb; code is right justified [RULE13]
      s_nxt.bitmask = 12'h001 << (nbits - 4'h1);
      s_nxt.code = '0;
      s_nxt.busy = 1'b1;
    end else if (s_r.busy) begin
      if (comp_i) begin
        s_nxt.code = s_r.code | s_r.bitmask; // sample above trial: keep bit [RULE13]
      end
      s_nxt.bitmask = s_r.bitmask >> 1;
      if (s_r.bitmask == 12'h001) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
    // trial is a flop on the 12 bit scale so the comparator answers the bit under test [RULE13]
    s_nxt.trial = (s_nxt.code | s_nxt.bitmask) << (`ATDSC_BITS_12 - nbits);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign trial_o = s_r.trial;
  assign busy_o = s_r.busy;
  assign done_o = s_r.done;
  assign result_o = s_r.code;
endmodule : atdsc_sar

// ### logic/atdsc_ctrl.sv
// trigger and sequence control for a ten channel converter
// assumes control bits come from a register file on the same clock; ext_pins_i is asynchronous
`timescale 1ns/1ps
`include "atdsc_consts.svh"
// Operation
// [RULE1] trigger source resets to channel 9, selectable by converter_control_1 source field
// [RULE2] trigger disabled: one sequence when continuous is 0, back to back when 1
// [RULE3] edge mode: one sequence per edge, falling when polarity 0, rising when 1
// [RULE4] level mode: convert continuously while trigger active, low or high by polarity
// [RULE5] active edge during a running conversion sets the trigger overrun flag
// [RULE6] first conversion starts on trigger reception, never before
// [RULE7] with trigger enabled, converter_control_5 writes start nothing
// [RULE8] level mode never raises overrun for deassert and reassert during a sequence
// [RULE9] level mode: trigger still active at sequence end starts next at once
// [RULE10] per channel digital buffer follows enable bit; pad always stays on the mux
// [RULE11] reset gives power down and documented reset values
// [RULE12] sequence done and compare requests each gated by own converter_control_2 enable
// [RULE13] 8, 10 or 12 bit result found by binary search
// [RULE14] exactly one of ten channels routed to the sample stage per conversion
// [RULE15] converter core powered down whenever no conversion runs
// [RULE16] converter_control_5 write starts sequence and clears all completion flags
// [RULE17] compare enabled and true sets completion flag and may request compare interrupt
// [RULE18] trigger synchronised by two flops, edges found from successive samples
module atdsc_ctrl
  import atdsc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [`ATDSC_NCH-1:0] ext_pins_i,
  input wire logic [`ATDSC_CHW-1:0] trigger_source_i,
  input wire logic trigger_source_wr_i,
  input wire logic external_trigger_enable_i,
  input wire logic trigger_level_select_i,
  input wire logic trigger_polarity_i,
  input wire logic continuous_sequence_i,
  input wire logic [1:0] resolution_i,
  input wire logic [`ATDSC_CHW-1:0] first_channel_i,
  input wire logic [`ATDSC_CHW-1:0] sequence_length_i,
  input wire logic converter_control_5_wr_i,
  input wire logic sequence_done_irq_enable_i,
  input wire logic compare_irq_enable_i,
  input wire logic [`ATDSC_NCH-1:0] compare_enable_i,
  input wire logic [`ATDSC_NCH-1:0] compare_higher_i,
  input wire logic [`ATDSC_RESW-1:0] compare_value_i,
  input wire logic [`ATDSC_NCH-1:0] digital_input_enable_reg_i,
  input wire logic [`ATDSC_NCH-1:0] flag_clear_i,
  input wire logic overrun_clear_i,
  input wire logic comparator_i,
  output logic [`ATDSC_CHW-1:0] mux_select_o,
  output logic sample_o,
  output logic core_power_o,
  output logic [`ATDSC_RESW-1:0] dac_code_o,
  output logic [`ATDSC_NCH-1:0] digital_buffer_en_o,
  output logic [`ATDSC_NCH-1:0] conversion_complete_flag_o,
  output logic trigger_overrun_flag_o,
  output logic [`ATDSC_RESW-1:0] result_o,
  output logic result_valid_o,
  output logic [`ATDSC_CHW-1:0] result_index_o,
  output logic sequence_done_irq_o,
  output logic compare_irq_o,
  output logic busy_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    atdsc_state_t st;
    logic [`ATDSC_CHW-1:0] trig_src;
    logic [`ATDSC_NCH-1:0] sync_a;
    logic [`ATDSC_NCH-1:0] sync_b;
    logic trig_prev;
    logic [`ATDSC_CHW-1:0] chan;
    logic [`ATDSC_CHW-1:0] conv_idx;
    logic [`ATDSC_NCH-1:0] ccf;
    logic trigger_overrun_flag;
    logic seq_flag;
    logic cmp_flag;
    logic [`ATDSC_RESW-1:0] result;
    logic rvalid;
    logic [`ATDSC_NCH-1:0] dien;
    logic [`ATDSC_CHW-1:0] ridx;
    logic samp;
    logic run;
    logic start_sar;
  } atdsc_ctrl_st_t;
  atdsc_ctrl_st_t s_r, s_nxt;

  logic trig_raw;
  logic trig_act;
  logic prev_act;
  logic edge_hit;
  logic seq_go;
  logic sar_busy;
  logic sar_done;
  logic [`ATDSC_RESW-1:0] sar_trial;
  logic [`ATDSC_RESW-1:0] sar_result;
  logic [`ATDSC_RESW-1:0] aligned;
  logic cmp_true;
  logic last_conv;

  atdsc_sar u_sar (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .start_i(s_r.start_sar),
    .res_i(resolution_i),
    .comp_i(comparator_i),
    .trial_o(sar_trial),
    .busy_o(sar_busy),
    .done_o(sar_done),
    .result_o(sar_result)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.start_sar = 1'b0;
    s_nxt.rvalid = 1'b0;
    // every pin passes two flops before the source mux, so a source change cannot upset a flop [RULE18]
    s_nxt.sync_a = ext_pins_i;
    s_nxt.sync_b = s_r.sync_a;
    trig_raw = s_r.sync_b[s_r.trig_src];
    s_nxt.trig_prev = trig_raw;
    // polarity folds the level to active high [RULE4]
    trig_act = trig_raw ~^ trigger_polarity_i;
    prev_act = s_r.trig_prev ~^ trigger_polarity_i;
    edge_hit = trig_act && !prev_act; // falling or rising by polarity [RULE3] [RULE18]
    if (trigger_source_wr_i) begin
      s_nxt.trig_src = trigger_source_i; // [RULE1]
    end
    s_nxt.dien = digital_input_enable_reg_i; // [RULE10]
    // sequence start decision
    seq_go = 1'b0;
    if (!external_trigger_enable_i) begin
      seq_go = converter_control_5_wr_i; // [RULE16] [RULE2]
    end else if (trigger_level_select_i) begin
      seq_go = trig_act && (s_r.st == ATDSC_OFF); // [RULE4] [RULE6] [RULE7]
    end else begin
      seq_go = edge_hit && (s_r.st == ATDSC_OFF); // [RULE3] [RULE6] [RULE7]
    end
    // overrun: only edge mode, active edge while busy [RULE5] [RULE8]
    if (external_trigger_enable_i && !trigger_level_select_i && edge_hit && s_r.st != ATDSC_OFF) begin
      s_nxt.trigger_overrun_flag = 1'b1;
    end else if (overrun_clear_i) begin
      s_nxt.trigger_overrun_flag = 1'b0;
    end
    // completion flag clears; set after this wins except for a sequence start
    s_nxt.ccf = s_r.ccf & ~flag_clear_i;
    s_nxt.seq_flag = 1'b0;
    s_nxt.cmp_flag = 1'b0;
    // result alignment is right justified per resolution, compare uses full 12 bits
    aligned = sar_result;
    cmp_true = compare_higher_i[s_r.conv_idx] ? (aligned > compare_value_i) : (aligned <= compare_value_i);
    last_conv = (s_r.conv_idx == sequence_length_i - 4'h1) || (s_r.conv_idx == `ATDSC_LAST_CH);
    case (s_r.st)
      ATDSC_OFF: begin
        if (seq_go) begin
          s_nxt.st = ATDSC_SAMPLE;
          s_nxt.chan = first_channel_i;
          s_nxt.conv_idx = '0;
          s_nxt.ccf = '0; // start clears all completion flags [RULE16]
        end
      end
      ATDSC_SAMPLE: begin
        s_nxt.start_sar = 1'b1;
        s_nxt.st = ATDSC_CONVERT;
      end
      ATDSC_CONVERT: begin
        if (sar_done) begin
          s_nxt.result = aligned;
          s_nxt.ridx = s_r.conv_idx; // index names the conversion just finished
          if (compare_enable_i[s_r.conv_idx]) begin
            if (cmp_true) begin
              s_nxt.ccf[s_r.conv_idx] = 1'b1; // [RULE17]
              s_nxt.cmp_flag = compare_irq_enable_i; // [RULE17] [RULE12]
            end
          end else begin
            s_nxt.ccf[s_r.conv_idx] = 1'b1;
            s_nxt.rvalid = 1'b1;
          end
          s_nxt.st = last_conv ? ATDSC_DONE : ATDSC_SAMPLE;
          s_nxt.conv_idx = s_r.conv_idx + 4'h1;
          s_nxt.chan = (s_r.chan == `ATDSC_LAST_CH) ? 4'h0 : s_r.chan + 4'h1; // one channel at a time [RULE14]
        end
      end
      ATDSC_DONE: begin
        s_nxt.seq_flag = sequence_done_irq_enable_i; // [RULE12]
        s_nxt.conv_idx = '0;
        s_nxt.chan = first_channel_i;
        if (!external_trigger_enable_i && continuous_sequence_i) begin
          s_nxt.st = ATDSC_SAMPLE; // [RULE2]
          s_nxt.ccf = '0;
        end else if (external_trigger_enable_i && trigger_level_select_i && trig_act) begin
          s_nxt.st = ATDSC_SAMPLE; // still active, rerun at once [RULE9] [RULE4]
          s_nxt.ccf = '0;
        end else begin
          s_nxt.st = ATDSC_OFF;
        end
      end
      default: begin
        s_nxt.st = ATDSC_OFF;
      end
    endcase
    // status outputs kept as flops of their own, decoded from the next state
    s_nxt.samp = (s_nxt.st == ATDSC_SAMPLE);
    s_nxt.run = (s_nxt.st != ATDSC_OFF); // [RULE15]
  end

  // ****************************************
  // registers; reset lands in power down
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.st <= ATDSC_OFF; // [RULE11]
      s_r.trig_src <= `ATDSC_TRIG_SRC_RST; // [RULE1] [RULE11]
      s_r.dien <= `ATDSC_DIEN_RST; // [RULE11]
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs, all from flops
  // ****************************************
  assign mux_select_o = s_r.chan; // [RULE14]
  assign sample_o = s_r.samp;
  // core powered only while a sequence runs, saves analog current [RULE15]
  assign core_power_o = s_r.run;
  assign dac_code_o = sar_trial; // registered inside the engine
  assign digital_buffer_en_o = s_r.dien; // pad stays on mux regardless [RULE10]
  assign conversion_complete_flag_o = s_r.ccf;
  assign trigger_overrun_flag_o = s_r.trigger_overrun_flag;
  assign result_o = s_r.result;
  assign result_valid_o = s_r.rvalid;
  assign result_index_o = s_r.ridx;
  assign sequence_done_irq_o = s_r.seq_flag;
  assign compare_irq_o = s_r.cmp_flag;
  assign busy_o = s_r.run;
endmodule : atdsc_ctrl

// ### tb/atdsc_ctrl_chk.sv
// assertion checker for the converter trigger and sequence control block
// assumes one clock domain; bound to every atdsc_ctrl instance below
`timescale 1ns/1ps
`include "atdsc_consts.svh"
module atdsc_ctrl_chk
  import atdsc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic external_trigger_enable_i,
  input wire logic trigger_level_select_i,
  input wire logic converter_control_5_wr_i,
  input wire logic sequence_done_irq_enable_i,
  input wire logic compare_irq_enable_i,
  input wire logic [`ATDSC_NCH-1:0] compare_enable_i,
  input wire logic [`ATDSC_NCH-1:0] digital_input_enable_reg_i,
  input wire logic [`ATDSC_CHW-1:0] mux_select_o,
  input wire logic sample_o,
  input wire logic core_power_o,
  input wire logic [`ATDSC_NCH-1:0] digital_buffer_en_o,
  input wire logic [`ATDSC_NCH-1:0] conversion_complete_flag_o,
  input wire logic trigger_overrun_flag_o,
  input wire logic sequence_done_irq_o,
  input wire logic compare_irq_o,
  input wire logic busy_o
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rst_idle; $rose(rst_n_i) |-> !busy_o && !core_power_o && conversion_complete_flag_o == 10'h000; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
  property p_power_off; !busy_o |-> !core_power_o; endproperty
  a_power_off: assert property (p_power_off) else $error("core powered while idle");
  property p_sw_start; !external_trigger_enable_i && converter_control_5_wr_i && !busy_o |=> busy_o && sample_o; endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start not taken");
  property p_mux_range; busy_o |-> mux_select_o <= `ATDSC_LAST_CH; endproperty
  a_mux_range: assert property (p_mux_range) else $error("channel out of range");
  // registered copy, so compare against the enable one edge back
  property p_dien; $past(rst_n_i) |-> digital_buffer_en_o == $past(digital_input_enable_reg_i); endproperty
  a_dien: assert property (p_dien) else $error("buffer enable mismatch");
  property p_done_gate; sequence_done_irq_o |-> sequence_done_irq_enable_i; endproperty
  a_done_gate: assert property (p_done_gate) else $error("done request not gated");
  property p_cmp_gate; compare_irq_o |-> compare_irq_enable_i && compare_enable_i != 10'h000; endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("compare request not gated");
  property p_lvl_no_ovr;
    external_trigger_enable_i && trigger_level_select_i && $stable(trigger_level_select_i) && !trigger_overrun_flag_o
      |=> !trigger_overrun_flag_o;
  endproperty
  a_lvl_no_ovr: assert property (p_lvl_no_ovr) else $error("overrun in level mode");
endmodule : atdsc_ctrl_chk

bind atdsc_ctrl atdsc_ctrl_chk i_chk (.mclk_i, .rst_n_i, .external_trigger_enable_i, .trigger_level_select_i,
  .converter_control_5_wr_i, .sequence_done_irq_enable_i, .compare_irq_enable_i, .compare_enable_i,
  .digital_input_enable_reg_i, .mux_select_o, .sample_o, .core_power_o, .digital_buffer_en_o,
  .conversion_complete_flag_o, .trigger_overrun_flag_o, .sequence_done_irq_o, .compare_irq_o, .busy_o);

// ### tb/atdsc_ana_model.sv
// far side model: trigger source and the analog levels of the ten pins
// assumes the converter trial code is left aligned on the 12 bit scale
`timescale 1ns/1ps
`include "atdsc_consts.svh"
module atdsc_ana_model
  import atdsc_pkg::*;
(
  input wire logic trig_i,
  input wire logic [`ATDSC_CHW-1:0] trig_ch_i,
  input wire logic [7:0] base_i,
  input wire logic [`ATDSC_CHW-1:0] mux_select_i,
  input wire logic [`ATDSC_RESW-1:0] dac_code_i,
  output logic [`ATDSC_NCH-1:0] pins_o,
  output logic comparator_o
);
  // low nibble sits mid code so coarse results come out exact
  logic [`ATDSC_RESW-1:0] lvl;
  always_comb begin
    lvl = {base_i + 8'h17 * 8'(mux_select_i), 4'hA};
    comparator_o = lvl > dac_code_i;
    pins_o = 10'h2AA;
    pins_o[trig_ch_i] = trig_i;
  end
endmodule : atdsc_ana_model

// ### tb/atdsc_ctrl_tb.sv
// self-checking bench for the converter trigger and sequence control block
// assumes the analog model and checker are compiled before it
`timescale 1ns/1ps
module atdsc_ctrl_tb
  import atdsc_pkg::*;
;
  logic mclk_i, rst_n_i, trigger_source_wr_i, external_trigger_enable_i, trigger_level_select_i, trig;
  logic trigger_polarity_i, continuous_sequence_i, converter_control_5_wr_i, sequence_done_irq_enable_i;
  logic compare_irq_enable_i, overrun_clear_i, comparator_i, sample_o, core_power_o, trigger_overrun_flag_o;
  logic result_valid_o, sequence_done_irq_o, compare_irq_o, busy_o;
  logic [1:0] resolution_i;
  logic [3:0] trigger_source_i, first_channel_i, sequence_length_i, mux_select_o, result_index_o, trig_ch;
  logic [9:0] ext_pins_i, compare_enable_i, compare_higher_i, digital_input_enable_reg_i, flag_clear_i;
  logic [9:0] digital_buffer_en_o, conversion_complete_flag_o;
  logic [11:0] compare_value_i, dac_code_o, result_o, lv;
  logic [7:0] base;
  int n_mismatch, cmp_count, n_done, n_cmp, k, e, d, c, cyc;
  int q[$];
  atdsc_ctrl i_dut (.mclk_i, .rst_n_i, .ext_pins_i, .trigger_source_i, .trigger_source_wr_i,
    .external_trigger_enable_i, .trigger_level_select_i, .trigger_polarity_i, .continuous_sequence_i,
    .resolution_i, .first_channel_i, .sequence_length_i, .converter_control_5_wr_i, .sequence_done_irq_enable_i,
    .compare_irq_enable_i, .compare_enable_i, .compare_higher_i, .compare_value_i, .digital_input_enable_reg_i,
    .flag_clear_i, .overrun_clear_i, .comparator_i, .mux_select_o, .sample_o, .core_power_o, .dac_code_o,
    .digital_buffer_en_o, .conversion_complete_flag_o, .trigger_overrun_flag_o, .result_o, .result_valid_o,
    .result_index_o, .sequence_done_irq_o, .compare_irq_o, .busy_o);
  atdsc_ana_model i_ana (.trig_i(trig), .trig_ch_i(trig_ch), .base_i(base), .mux_select_i(mux_select_o),
    .dac_code_i(dac_code_o), .pins_o(ext_pins_i), .comparator_o(comparator_i));
  // ****************************************
  // clock, checks, model
  // ****************************************
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic start_seq();
    @(posedge mclk_i);
    converter_control_5_wr_i <= 1'b1;
    @(posedge mclk_i);
    converter_control_5_wr_i <= 1'b0;
  endtask : start_seq
  // trailing cycles let the done request of the last sequence land
  task automatic wait_idle();
    @(negedge mclk_i);
    for (int t = 0; t < 3000 && busy_o !== 1'b0; t++) @(negedge mclk_i);
    repeat (3) @(negedge mclk_i);
  endtask : wait_idle
  task automatic wait_cnt(int n);
    for (int t = 0; t < 2000 && n_done < n; t++) @(negedge mclk_i);
  endtask : wait_cnt
  // expected channel per conversion and its result, from the pin levels
  always @(negedge mclk_i) begin
    if (rst_n_i) begin
      if (sample_o === 1'b1) begin
        check("mux", mux_select_o, (first_channel_i + k) % 10);
        q.push_back(k * 16 + (first_channel_i + k) % 10);
        k = (k + 1) % sequence_length_i;
      end
      if (result_valid_o === 1'b1 && q.size() > 0) begin
        e = q.pop_front();
        lv = {base + 8'h17 * 8'(e % 16), 4'hA};
        lv = resolution_i == 2'h0 ? lv >> 4 : resolution_i == 2'h1 ? lv >> 2 : lv;
        if (!compare_enable_i[e / 16]) check("result", 12'(lv - result_o) <= 12'h001, 1);
        check("index", result_index_o, e / 16);
      end
      n_done += sequence_done_irq_o;
      n_cmp += compare_irq_o;
    end
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(43590));
    {rst_n_i, trigger_source_wr_i, external_trigger_enable_i, trigger_level_select_i, trigger_polarity_i, trig,
     continuous_sequence_i, converter_control_5_wr_i, compare_irq_enable_i, overrun_clear_i, resolution_i,
     trigger_source_i, first_channel_i, compare_enable_i, compare_higher_i, compare_value_i,
     digital_input_enable_reg_i, flag_clear_i, base} = '0;
    {sequence_done_irq_enable_i, sequence_length_i, trig_ch} = {1'b1, 4'h1, 4'h9};
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    check("reset", {busy_o, core_power_o, trigger_overrun_flag_o, conversion_complete_flag_o}, 0);
    @(posedge mclk_i);
    digital_input_enable_reg_i <= 10'($urandom);
    repeat (2) @(negedge mclk_i);
    check("dien", digital_buffer_en_o, digital_input_enable_reg_i);
    repeat (2) begin
      @(posedge mclk_i);
      trig <= !trig;
      repeat (5) @(negedge mclk_i);
      check("ignored", busy_o, 0);
    end
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk_i);
      resolution_i <= 2'(r % 3);
      first_channel_i <= 4'($urandom_range(9));
      sequence_length_i <= r == 3 ? 4'h2 : 4'($urandom_range(10, 1));
      base <= 8'($urandom);
      sequence_done_irq_enable_i <= 1'(r != 1);
      {compare_enable_i, compare_higher_i, compare_value_i, compare_irq_enable_i} <= {10'(r / 3 * 3), 10'h002, 12'hFFF, 1'b1};
      q.delete();
      k = 0;
      d = n_done;
      c = n_cmp;
      start_seq();
      wait_idle();
      check("flags", conversion_complete_flag_o, r == 3 ? 1 : (1 << sequence_length_i) - 1);
      check("done", n_done - d, r != 1);
      check("cmp irq", n_cmp - c, r == 3);
      check("power", core_power_o, 0);
    end
    @(posedge mclk_i);
    {flag_clear_i, compare_enable_i, continuous_sequence_i} <= {10'h3FF, 10'h000, 1'b1};
    @(posedge mclk_i);
    flag_clear_i <= 10'h000;
    @(negedge mclk_i);
    check("clear", conversion_complete_flag_o, 0);
    q.delete();
    k = 0;
    d = n_done;
    start_seq();
    wait_cnt(d + 2);
    @(posedge mclk_i);
    continuous_sequence_i <= 1'b0;
    wait_idle();
    check("continuous", n_done - d >= 2, 1);
    for (int m = 0; m < 2; m++) for (int p = 0; p < 2; p++) begin
      @(posedge mclk_i);
      {external_trigger_enable_i, trigger_level_select_i, trigger_polarity_i, trig} <= {1'b0, 1'(m), 1'(p), 1'(!p)};
      {trigger_source_i, trigger_source_wr_i, trig_ch} <= {4'h3, 1'(m == 0 && p == 1), m + p > 0 ? 4'h3 : 4'h9};
      @(posedge mclk_i);
      trigger_source_wr_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      external_trigger_enable_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      start_seq();
      repeat (4) @(negedge mclk_i);
      check("sw start", busy_o, 0);
      q.delete();
      k = 0;
      d = n_done;
      @(posedge mclk_i);
      trig <= 1'(p);
      repeat (6) @(negedge mclk_i);
      check("trig start", busy_o, 1);
      @(posedge mclk_i);
      trig <= 1'(!p);
      repeat (3) @(posedge mclk_i);
      trig <= 1'(p);
      if (m == 1) wait_cnt(d + 2);
      @(posedge mclk_i);
      trig <= 1'(!p);
      wait_idle();
      check("overrun", trigger_overrun_flag_o, m == 0);
      check("seqs", m ? n_done - d >= 2 : n_done - d, 1);
      @(posedge mclk_i);
      overrun_clear_i <= 1'b1;
      @(posedge mclk_i);
      overrun_clear_i <= 1'b0;
    end
    end_sim();
  end
endmodule : atdsc_ctrl_tb
